// ===== rtl/dual_serial_register_port.sv
// slave serial register port: I2C oversampled on clk, SPI on its own serial clock
`timescale 1ns/1ps
`default_nettype none
module dual_serial_register_port (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic csb,
   input wire logic sdi_i,
   output logic sdi_o,
   output logic sdi_oe,
   input wire logic sdo_i,
   output logic sdo_o,
   output logic sdo_oe,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   output logic fifo_flush,
   output logic soft_reset,
   output logic three_wire_select,
   output logic spi_locked,
   output logic spi_mode11
);
   // ---------------- synchronised pins and link toggles ----------------
   logic [3:0] pins_s;
   logic [1:0] tog_s;
   logic csb_s, scl_s, sda_s, sa0_s;
   logic spi_wr_tog_r, spi_rd_tog_r;

   pin_sync #(.WIDTH(4), .INIT(serial_port_pkg::PIN_SYNC_INIT)) u_pin_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({csb, sck, sdi_i, sdo_i}),
      .q(pins_s)
   );
   pin_sync #(.WIDTH(2), .INIT(serial_port_pkg::TOGGLE_SYNC_INIT)) u_tog_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({spi_wr_tog_r, spi_rd_tog_r}),
      .q(tog_s)
   );
   assign csb_s = pins_s[3];
   assign scl_s = pins_s[2];
   assign sda_s = pins_s[1];
   assign sa0_s = pins_s[0];

   // ---------------- I2C slave, oversampled on clk ----------------
   serial_port_pkg::i2c_state_type i_state_r, i_state_nxt;
   logic scl_d_r, scl_d_nxt, sda_d_r, sda_d_nxt;
   logic [7:0] i_sh_r, i_sh_nxt, i_tx_r, i_tx_nxt, i_ptr_r, i_ptr_nxt;
   logic [2:0] i_cnt_r, i_cnt_nxt;
   logic i_rw_r, i_rw_nxt, i_regph_r, i_regph_nxt, i_oe_r, i_oe_nxt;
   logic i_wr_req, i_rd_req;
   logic [7:0] i_req_addr, i_req_data;
   logic spi_lock_r;
   logic [7:0] rd_data_r;

   logic start_ev, stop_ev, scl_rise, scl_fall;
   logic [7:0] i_byte;
   assign start_ev = scl_d_r && scl_s && sda_d_r && !sda_s;
   assign stop_ev = scl_d_r && scl_s && !sda_d_r && sda_s;
   assign scl_rise = !scl_d_r && scl_s;
   assign scl_fall = scl_d_r && !scl_s;
   assign i_byte = {i_sh_r[6:0], sda_s};

   always_comb begin
      i_state_nxt = i_state_r;
      scl_d_nxt = scl_s;
      sda_d_nxt = sda_s;
      i_sh_nxt = i_sh_r;
      i_tx_nxt = i_tx_r;
      i_ptr_nxt = i_ptr_r;
      i_cnt_nxt = i_cnt_r;
      i_rw_nxt = i_rw_r;
      i_regph_nxt = i_regph_r;
      i_oe_nxt = i_oe_r;
      i_wr_req = 1'h0;
      i_rd_req = 1'h0;
      i_req_addr = i_ptr_r;
      i_req_data = i_byte;
      if (spi_lock_r) begin
         i_state_nxt = serial_port_pkg::I_IDLE;
         i_oe_nxt = 1'h0;
      end else if (start_ev) begin
         i_state_nxt = serial_port_pkg::I_ADDR;
         i_cnt_nxt = 3'h0;
         i_oe_nxt = 1'h0;
      end else if (stop_ev) begin
         i_state_nxt = serial_port_pkg::I_IDLE;
         i_oe_nxt = 1'h0;
      end else begin
         case (i_state_r)
            serial_port_pkg::I_ADDR: begin
               if (scl_rise) begin
                  i_sh_nxt = i_byte;
                  i_cnt_nxt = i_cnt_r + 3'h1;
                  if (i_cnt_r == serial_port_pkg::LAST_BIT) begin
                     if (i_byte[7:1] == {serial_port_pkg::I2C_ADDR_HIGH, sa0_s}) begin
                        i_state_nxt = serial_port_pkg::I_ACK;
                        i_rw_nxt = i_byte[0];
                        i_regph_nxt = 1'h1;
                        i_rd_req = i_byte[0];
                     end else begin
                        i_state_nxt = serial_port_pkg::I_IDLE;
                     end
                  end
               end
            end
            serial_port_pkg::I_ACK: begin
               if (scl_fall) begin
                  i_cnt_nxt = 3'h0;
                  if (!i_oe_r) begin
                     i_oe_nxt = 1'h1;
                  end else if (i_rw_r) begin
                     i_tx_nxt = rd_data_r;
                     i_oe_nxt = !rd_data_r[7];
                     i_state_nxt = serial_port_pkg::I_TX;
                  end else begin
                     i_oe_nxt = 1'h0;
                     i_state_nxt = serial_port_pkg::I_RX;
                  end
               end
            end
            serial_port_pkg::I_RX: begin
               if (scl_rise) begin
                  i_sh_nxt = i_byte;
                  i_cnt_nxt = i_cnt_r + 3'h1;
                  if (i_cnt_r == serial_port_pkg::LAST_BIT) begin
                     i_state_nxt = serial_port_pkg::I_ACK;
                     i_regph_nxt = !i_regph_r;
                     if (i_regph_r) begin
                        i_ptr_nxt = i_byte;
                     end else begin
                        i_wr_req = 1'h1;
                     end
                  end
               end
            end
            serial_port_pkg::I_TX: begin
               if (scl_rise) begin
                  i_cnt_nxt = i_cnt_r + 3'h1;
                  if (i_cnt_r == serial_port_pkg::LAST_BIT) begin
                     i_state_nxt = serial_port_pkg::I_MACK;
                     i_ptr_nxt = i_ptr_r + 8'h01;
                     i_req_addr = i_ptr_r + 8'h01;
                     i_rd_req = 1'h1;
                  end
               end else if (scl_fall) begin
                  i_tx_nxt = {i_tx_r[6:0], 1'h0};
                  i_oe_nxt = !i_tx_r[6];
               end
            end
            serial_port_pkg::I_MACK: begin
               if (scl_fall) begin
                  i_oe_nxt = 1'h0;
               end else if (scl_rise) begin
                  // a not-acknowledge ends the burst; the stop then follows
                  i_state_nxt = sda_s ? serial_port_pkg::I_IDLE : serial_port_pkg::I_LOAD;
               end
            end
            serial_port_pkg::I_LOAD: begin
               if (scl_fall) begin
                  i_tx_nxt = rd_data_r;
                  i_oe_nxt = !rd_data_r[7];
                  i_cnt_nxt = 3'h0;
                  i_state_nxt = serial_port_pkg::I_TX;
               end
            end
            default: begin
               i_state_nxt = serial_port_pkg::I_IDLE;
               i_oe_nxt = 1'h0;
            end
         endcase
      end
   end

   // oversampling sees each scl edge two clk late, through the two-flop pin synchroniser
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         i_state_r <= serial_port_pkg::I_IDLE;
         scl_d_r <= 1'h1;
         sda_d_r <= 1'h1;
         i_sh_r <= 8'h00;
         i_tx_r <= 8'h00;
         i_ptr_r <= 8'h00;
         i_cnt_r <= 3'h0;
         i_rw_r <= 1'h0;
         i_regph_r <= 1'h1;
         i_oe_r <= 1'h0;
      end else begin
         i_state_r <= i_state_nxt;
         scl_d_r <= scl_d_nxt;
         sda_d_r <= sda_d_nxt;
         i_sh_r <= i_sh_nxt;
         i_tx_r <= i_tx_nxt;
         i_ptr_r <= i_ptr_nxt;
         i_cnt_r <= i_cnt_nxt;
         i_rw_r <= i_rw_nxt;
         i_regph_r <= i_regph_nxt;
         i_oe_r <= i_oe_nxt;
      end
   end

   // ---------------- register access, command and interface control ----------------
   logic csb_d_r, csb_d_nxt, spi_lock_nxt, mode11_r, mode11_nxt, cfg3w_r, cfg3w_nxt;
   logic wr_seen_r, wr_seen_nxt, rd_seen_r, rd_seen_nxt, rd_pend_r, rd_pend_nxt;
   logic [7:0] rd_data_nxt, reg_addr_r, reg_addr_nxt, reg_wdata_r, reg_wdata_nxt;
   logic reg_wr_r, reg_wr_nxt, reg_rd_r, reg_rd_nxt;
   logic flush_r, flush_nxt, sreset_r, sreset_nxt;
   logic [6:0] spi_wr_addr_r, spi_rd_addr_r;
   logic [7:0] spi_wr_data_r;
   logic do_wr, do_rd;
   logic [7:0] acc_addr, acc_data;

   always_comb begin
      csb_d_nxt = csb_s;
      spi_lock_nxt = spi_lock_r | !csb_s;
      mode11_nxt = (csb_d_r && !csb_s) ? scl_s : mode11_r;
      wr_seen_nxt = tog_s[1];
      rd_seen_nxt = tog_s[0];
      cfg3w_nxt = cfg3w_r;
      flush_nxt = 1'h0;
      sreset_nxt = 1'h0;
      reg_wr_nxt = 1'h0;
      reg_rd_nxt = 1'h0;
      reg_addr_nxt = reg_addr_r;
      reg_wdata_nxt = reg_wdata_r;
      rd_data_nxt = rd_data_r;
      do_wr = (tog_s[1] != wr_seen_r) || i_wr_req;
      do_rd = (tog_s[0] != rd_seen_r) || i_rd_req;
      acc_addr = (tog_s[1] != wr_seen_r) ? {1'h0, spi_wr_addr_r} : i_req_addr;
      acc_data = (tog_s[1] != wr_seen_r) ? spi_wr_data_r : i_req_data;
      if (!do_wr && (tog_s[0] != rd_seen_r)) begin
         acc_addr = {1'h0, spi_rd_addr_r};
      end
      if (rd_pend_r) begin
         if (reg_addr_r == serial_port_pkg::CMD_ADDR) begin
            rd_data_nxt = serial_port_pkg::CMD_READ_VALUE;
         end else if (reg_addr_r == serial_port_pkg::INTERFACE_CONFIG_ADDR) begin
            rd_data_nxt = {7'h00, cfg3w_r};
         end else begin
            rd_data_nxt = reg_rdata;
         end
      end
      rd_pend_nxt = do_rd && !do_wr;
      if (do_wr) begin
         reg_addr_nxt = acc_addr;
         reg_wdata_nxt = acc_data;
         if (acc_addr == serial_port_pkg::CMD_ADDR) begin
            flush_nxt = (acc_data == serial_port_pkg::CMD_FIFO_FLUSH);
            sreset_nxt = (acc_data == serial_port_pkg::CMD_SOFT_RESET);
            if (acc_data == serial_port_pkg::CMD_SOFT_RESET) begin
               cfg3w_nxt = serial_port_pkg::INTERFACE_CONFIG_RESET;
            end
         end else if (acc_addr == serial_port_pkg::INTERFACE_CONFIG_ADDR) begin
            cfg3w_nxt = acc_data[serial_port_pkg::THREE_WIRE_BIT];
         end else begin
            reg_wr_nxt = 1'h1;
         end
      end else if (do_rd) begin
         reg_addr_nxt = acc_addr;
         reg_rd_nxt = 1'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         csb_d_r <= 1'h1;
         spi_lock_r <= 1'h0;
         mode11_r <= 1'h0;
         cfg3w_r <= serial_port_pkg::INTERFACE_CONFIG_RESET;
         wr_seen_r <= 1'h0;
         rd_seen_r <= 1'h0;
         rd_pend_r <= 1'h0;
         rd_data_r <= 8'h00;
         reg_addr_r <= 8'h00;
         reg_wdata_r <= 8'h00;
         reg_wr_r <= 1'h0;
         reg_rd_r <= 1'h0;
         flush_r <= 1'h0;
         sreset_r <= 1'h0;
      end else begin
         csb_d_r <= csb_d_nxt;
         spi_lock_r <= spi_lock_nxt;
         mode11_r <= mode11_nxt;
         cfg3w_r <= cfg3w_nxt;
         wr_seen_r <= wr_seen_nxt;
         rd_seen_r <= rd_seen_nxt;
         rd_pend_r <= rd_pend_nxt;
         rd_data_r <= rd_data_nxt;
         reg_addr_r <= reg_addr_nxt;
         reg_wdata_r <= reg_wdata_nxt;
         reg_wr_r <= reg_wr_nxt;
         reg_rd_r <= reg_rd_nxt;
         flush_r <= flush_nxt;
         sreset_r <= sreset_nxt;
      end
   end

   // ---------------- SPI link, clocked by sck ----------------
   // frame state clears while deselected, since sck may stand still then
   logic frame_rst;
   assign frame_rst = csb | !rst_n;
   logic [2:0] s_cnt_r, s_cnt_nxt;
   logic [6:0] s_sh_r, s_sh_nxt, spi_wr_addr_nxt, spi_rd_addr_nxt;
   logic [7:0] s_byte, spi_wr_data_nxt, s_tx_r, s_tx_nxt;
   serial_port_pkg::spi_phase_type s_ph_r, s_ph_nxt;
   logic spi_wr_tog_nxt, spi_rd_tog_nxt, s_rd_now;
   logic s_sdo_oe_r, s_sdo_oe_nxt, s_sdi_oe_r, s_sdi_oe_nxt;
   assign s_byte = {s_sh_r, sdi_i};
   assign s_rd_now = (s_ph_r == serial_port_pkg::S_RDATA);

   always_comb begin
      s_cnt_nxt = s_cnt_r + 3'h1;
      s_sh_nxt = s_byte[6:0];
      s_ph_nxt = s_ph_r;
      spi_wr_addr_nxt = spi_wr_addr_r;
      spi_rd_addr_nxt = spi_rd_addr_r;
      spi_wr_data_nxt = spi_wr_data_r;
      spi_wr_tog_nxt = spi_wr_tog_r;
      spi_rd_tog_nxt = spi_rd_tog_r;
      if (s_cnt_r == serial_port_pkg::LAST_BIT) begin
         case (s_ph_r)
            serial_port_pkg::S_CTRL: begin
               s_ph_nxt = s_byte[7] ? serial_port_pkg::S_RDUMMY : serial_port_pkg::S_WDATA;
               spi_wr_addr_nxt = s_byte[6:0];
               spi_rd_addr_nxt = s_byte[6:0];
               spi_rd_tog_nxt = spi_rd_tog_r ^ s_byte[7];
            end
            serial_port_pkg::S_WDATA: begin
               s_ph_nxt = serial_port_pkg::S_CTRL;
               spi_wr_data_nxt = s_byte;
               spi_wr_tog_nxt = !spi_wr_tog_r;
            end
            serial_port_pkg::S_RDUMMY: begin
               s_ph_nxt = serial_port_pkg::S_RDATA;
            end
            default: begin
               s_ph_nxt = s_ph_r;
            end
         endcase
      end else if (s_rd_now && s_cnt_r == serial_port_pkg::PREFETCH_BIT) begin
         // fetch the next byte mid-byte: the clk side needs several cycles
         spi_rd_addr_nxt = spi_rd_addr_r + 7'h01;
         spi_rd_tog_nxt = !spi_rd_tog_r;
      end
      s_tx_nxt = (s_rd_now && s_cnt_r == 3'h0) ? rd_data_r : {s_tx_r[6:0], 1'h0};
      s_sdo_oe_nxt = s_rd_now && !cfg3w_r;
      s_sdi_oe_nxt = s_rd_now && cfg3w_r;
   end

   always_ff @(posedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         s_cnt_r <= 3'h0;
         s_sh_r <= 7'h00;
         s_ph_r <= serial_port_pkg::S_CTRL;
      end else begin
         s_cnt_r <= s_cnt_nxt;
         s_sh_r <= s_sh_nxt;
         s_ph_r <= s_ph_nxt;
      end
   end

   // toggles survive deselect so the clk side never sees a false request
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         spi_wr_addr_r <= 7'h00;
         spi_rd_addr_r <= 7'h00;
         spi_wr_data_r <= 8'h00;
         spi_wr_tog_r <= 1'h0;
         spi_rd_tog_r <= 1'h0;
      end else begin
         spi_wr_addr_r <= spi_wr_addr_nxt;
         spi_rd_addr_r <= spi_rd_addr_nxt;
         spi_wr_data_r <= spi_wr_data_nxt;
         spi_wr_tog_r <= spi_wr_tog_nxt;
         spi_rd_tog_r <= spi_rd_tog_nxt;
      end
   end

   always_ff @(negedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         s_tx_r <= 8'h00;
         s_sdo_oe_r <= 1'h0;
         s_sdi_oe_r <= 1'h0;
      end else begin
         s_tx_r <= s_tx_nxt;
         s_sdo_oe_r <= s_sdo_oe_nxt;
         s_sdi_oe_r <= s_sdi_oe_nxt;
      end
   end

   assign sdo_o = s_tx_r[7];
   assign sdo_oe = s_sdo_oe_r;
   // the lock parts the two protocols, so only one side owns the shared pin
   assign sdi_o = spi_lock_r ? s_tx_r[7] : 1'h0;
   assign sdi_oe = spi_lock_r ? s_sdi_oe_r : i_oe_r;
   assign reg_addr = reg_addr_r;
   assign reg_wdata = reg_wdata_r;
   assign reg_wr = reg_wr_r;
   assign reg_rd = reg_rd_r;
   assign fifo_flush = flush_r;
   assign soft_reset = sreset_r;
   assign three_wire_select = cfg3w_r;
   assign spi_locked = spi_lock_r;
   assign spi_mode11 = mode11_r;

endmodule : dual_serial_register_port
`default_nettype wire

// ===== rtl/pin_sync.sv
// two-flop synchroniser bank, one pair per bit
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_r;
         logic meta_nxt;
         logic q_r;
         logic q_nxt;
         always_comb begin
            meta_nxt = d[i];
            q_nxt = meta_r;
         end
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               meta_r <= INIT[i];
               q_r <= INIT[i];
            end else begin
               meta_r <= meta_nxt;
               q_r <= q_nxt;
            end
         end
         assign q[i] = q_r;
      end
   endgenerate
endmodule : pin_sync
`default_nettype wire

// ===== rtl/serial_port_pkg.sv
// constants, field positions and state types of the dual serial register port
package serial_port_pkg;
   localparam logic [7:0] CMD_ADDR = 8'h7E;
   localparam logic [7:0] INTERFACE_CONFIG_ADDR = 8'h1A;
   localparam logic [7:0] CMD_READ_VALUE = 8'h00;
   localparam logic [7:0] CMD_FIFO_FLUSH = 8'hB0;
   localparam logic [7:0] CMD_SOFT_RESET = 8'hB6;
   localparam int THREE_WIRE_BIT = 0;
   localparam logic INTERFACE_CONFIG_RESET = 1'h0;
   localparam logic [5:0] I2C_ADDR_HIGH = 6'h3B;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] PREFETCH_BIT = 3'h3;
   localparam logic [3:0] PIN_SYNC_INIT = 4'hF;
   localparam logic [1:0] TOGGLE_SYNC_INIT = 2'h0;

   typedef enum logic [2:0] {
      I_IDLE = 3'h0,
      I_ADDR = 3'h1,
      I_ACK = 3'h2,
      I_RX = 3'h3,
      I_TX = 3'h4,
      I_MACK = 3'h5,
      I_LOAD = 3'h6
   } i2c_state_type;

   typedef enum logic [1:0] {
      S_CTRL = 2'h0,
      S_WDATA = 2'h1,
      S_RDUMMY = 2'h2,
      S_RDATA = 2'h3
   } spi_phase_type;
endpackage : serial_port_pkg

// ===== test/serial_port_assertions.sv
// concurrent checks on the serial port's pins and strobes
`timescale 1ns/1ps
`default_nettype none
module serial_port_assertions (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic csb,
   input wire logic sdi_oe,
   input wire logic sdo_oe,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic fifo_flush,
   input wire logic soft_reset,
   input wire logic three_wire_select,
   input wire logic spi_locked
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // csb crosses a synchroniser, so the lock is given a few cycles
   lock_entry_a: assert property ($fell(csb) |-> ##[1:6] spi_locked)
      else $error("chip-select low did not lock the port");
   lock_hold_a: assert property (spi_locked |=> spi_locked)
      else $error("lock released without reset");
   false_lock_a: assert property (csb && !spi_locked |=> !spi_locked)
      else $error("lock taken while chip-select high");
   idle_release_a: assert property ((csb && spi_locked) [*4] |-> !sdo_oe && !sdi_oe)
      else $error("data output driven while deselected");
   three_wire_a: assert property (three_wire_select |-> !sdo_oe)
      else $error("sdo driven in three-wire wiring");
   four_wire_a: assert property (spi_locked && !three_wire_select |-> !sdi_oe)
      else $error("sdi driven in four-wire wiring");
   strobe_excl_a: assert property (!(reg_wr && reg_rd))
      else $error("read and write strobes together");
   cmd_excl_a: assert property (!(fifo_flush && soft_reset))
      else $error("flush and reset strobes together");
   soft_default_a: assert property (soft_reset |-> ##[0:4] !three_wire_select)
      else $error("wiring select kept through soft reset");
endmodule : serial_port_assertions

bind dual_serial_register_port serial_port_assertions chk (
   .clk(clk),
   .rst_n(rst_n),
   .csb(csb),
   .sdi_oe(sdi_oe),
   .sdo_oe(sdo_oe),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .fifo_flush(fifo_flush),
   .soft_reset(soft_reset),
   .three_wire_select(three_wire_select),
   .spi_locked(spi_locked)
);
`default_nettype wire

// ===== test/spi_host_model.sv
// host-side serial master model driving the link pins
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   output logic sck,
   output logic csb,
   output logic mosi,
   output logic mosi_en,
   input wire logic miso
);
   initial begin
      sck = 1'b0;
      csb = 1'b1;
      mosi = 1'b0;
      mosi_en = 1'b0;
   end

   // 160 ns link period; the 43 ns lead keeps edges off the system clock
   task automatic frame(input logic cpol, input logic [7:0] tx[4], input int n,
      input logic rd, output logic [7:0] rx[4]);
      sck = cpol;
      #43 csb = 1'b0;
      #200;
      for (int b = 0; b < n; b++) begin
         for (int i = 7; i >= 0; i--) begin
            #80 sck = 1'b0;
            mosi_en = !(rd && b > 0);
            mosi = tx[b][i];
            #80 sck = 1'b1;
            rx[b][i] = miso;
         end
      end
      #80 sck = cpol;
      #80 mosi_en = 1'b0;
      csb = 1'b1;
      #400;
   endtask : frame
endmodule : spi_host_model
`default_nettype wire

// ===== test/test_dual_serial_register_port.sv
// self-checking bench for the dual serial register port over spi
`timescale 1ns/1ps
`default_nettype none
module test_dual_serial_register_port;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sck, csb, mosi, mosi_en, sdi_o, sdi_oe, sdo_o, sdo_oe;
   logic reg_wr, reg_rd, fifo_flush, soft_reset, three_wire_select, spi_locked, spi_mode11;
   logic [7:0] reg_addr, reg_wdata, wa, wd;
   logic sa0 = 1'b0;
   logic tw = 1'b0;
   logic fl = 1'b0;
   logic sr = 1'b0;
   logic [7:0] rx[4];
   int nwr = 0;
   int cyc = 0;
   int miscompares = 0;
   int n_tests = 0;
   // a released data line shows the inverse of its last value
   wire logic sdi_line = sdi_oe ? sdi_o : (mosi_en ? mosi : !mosi);
   wire logic sdo_line = sdo_oe ? sdo_o : sa0;
   // register side stand-in answers with the inverted address
   wire logic [7:0] reg_rdata = ~reg_addr;

   initial forever #5 clk = ~clk;

   spi_host_model host (.sck(sck), .csb(csb), .mosi(mosi), .mosi_en(mosi_en),
      .miso(tw ? sdi_line : sdo_line));

   dual_serial_register_port DUT (.clk(clk), .rst_n(rst_n), .sck(sck), .csb(csb),
      .sdi_i(sdi_line), .sdi_o(sdi_o), .sdi_oe(sdi_oe), .sdo_i(sdo_line), .sdo_o(sdo_o),
      .sdo_oe(sdo_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fifo_flush(fifo_flush),
      .soft_reset(soft_reset), .three_wire_select(three_wire_select),
      .spi_locked(spi_locked), .spi_mode11(spi_mode11));

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   always @(posedge clk) begin
      cyc++;
      if (reg_wr === 1'b1) begin
         wa = reg_addr;
         wd = reg_wdata;
         nwr++;
      end
      if (fifo_flush === 1'b1) fl = 1'b1;
      if (soft_reset === 1'b1) sr = 1'b1;
      if (cyc == 20000) begin
         miscompares++;
         $display("wrong value at %0t: run did not finish", $time);
         tally_and_finish();
      end
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %b want %b", $time, what, got, exp);
      end
   endtask : chk1

   task automatic run(input logic cpol, input logic [7:0] tx[4], input int n,
      input logic rd);
      host.frame(cpol, tx, n, rd, rx);
      repeat (20) @(posedge clk);
   endtask : run

   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk1(spi_locked, 1'b0, "lock after reset");
      chk1(three_wire_select, 1'b0, "wiring after reset");
      chk1(sdo_oe, 1'b0, "sdo idle");
      $display("test reset done");
      run(1'b0, '{8'h1B, 8'h5A, 8'h1C, 8'h33}, 4, 1'b0);
      chk1(spi_locked, 1'b1, "lock taken");
      chk8(8'(nwr), 8'h02, "write count");
      chk8(wa, 8'h1C, "write address");
      chk8(wd, 8'h33, "write data");
      chk1(spi_mode11, 1'b0, "mode 00");
      $display("test write done");
      run(1'b1, '{8'h90, 8'h00, 8'h00, 8'h00}, 4, 1'b1);
      chk8(rx[2], 8'hEF, "first read");
      chk8(rx[3], 8'hEE, "second read");
      chk1(spi_mode11, 1'b1, "mode 11");
      run(1'b0, '{8'hFE, 8'h00, 8'h00, 8'h00}, 3, 1'b1);
      chk8(rx[2], 8'h00, "command read");
      $display("test read done");
      run(1'b0, '{8'h7E, 8'hB0, 8'h1A, 8'h01}, 4, 1'b0);
      chk1(fl, 1'b1, "flush strobe");
      chk1(sr, 1'b0, "reset strobe idle");
      chk1(three_wire_select, 1'b1, "three wire on");
      tw = 1'b1;
      run(1'b1, '{8'h85, 8'h00, 8'h00, 8'h00}, 3, 1'b1);
      chk8(rx[2], 8'hFA, "three wire read");
      run(1'b0, '{8'h7E, 8'hB6, 8'h00, 8'h00}, 2, 1'b0);
      tw = 1'b0;
      chk1(sr, 1'b1, "reset strobe");
      chk1(three_wire_select, 1'b0, "wiring default");
      repeat (100) @(posedge clk);
      chk1(spi_locked, 1'b1, "lock kept");
      $display("test command done");
      tally_and_finish();
   end
endmodule : test_dual_serial_register_port
`default_nettype wire
